// ### shared/tqe_pkg.sv
// package: constants, types and helpers shared by the timing query target
package tqe_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_MODES  = 5'h04;
  localparam logic [4:0] OFF_OSC    = 5'h08;
  localparam logic [4:0] OFF_ID_LO  = 5'h0C;
  localparam logic [4:0] OFF_ID_HI  = 5'h10;
  localparam logic [4:0] OFF_STATUS = 5'h14;
  localparam logic [4:0] OFF_MASK   = 5'h18;
  localparam logic [4:0] OFF_BUSST  = 5'h1C;

  // control register bits
  localparam int CTRL_EN   = 0;
  localparam int CTRL_MON  = 1;
  localparam int CTRL_SLOW = 2;
  localparam int CTRL_W    = 3;

  // register field positions
  localparam int MODE_W        = 5;
  localparam int MODES_EN_LSB  = 8;
  localparam int OSC_INACC_LSB = 8;
  localparam int STATE_OVF_BIT = 7;
  localparam int BUSST_VALID   = 7;
  localparam int BUSST_OVF     = 8;
  localparam int BUSST_ARB     = 9;
  localparam int BUSST_RX_LSB  = 16;

  // event bits of status and mask
  localparam int EV_S0    = 0;
  localparam int EV_S1    = 1;
  localparam int EV_S2    = 2;
  localparam int EV_S3    = 3;
  localparam int EV_S4    = 4;
  localparam int EV_S5    = 5;
  localparam int EV_S6    = 6;
  localparam int EV_QUERY = 7;
  localparam int EV_WRX   = 8;
  localparam int EV_ADDR  = 9;
  localparam int EV_W     = 10;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST  = 3'h3;
  localparam logic [MODE_W-1:0] SUP_RST   = 5'h01;
  localparam logic [MODE_W-1:0] EN_RST    = 5'h00;
  localparam logic [7:0]        FREQ_RST  = 8'h50;
  localparam logic [7:0]        INACC_RST = 8'h0A;
  localparam logic [31:0]       ID_LO_RST = 32'h0000_0001; // arbitrary value
  localparam logic [31:0]       ID_HI_RST = 32'h0000_0000; // arbitrary value

  // serial bus figures
  localparam logic [6:0] ADDR_BCAST  = 7'h7E;
  localparam logic [6:0] HEAD_LAST   = 7'h07;
  localparam logic [6:0] BYTE_END    = 7'h08;
  localparam logic [6:0] ARB_ID_LAST = 7'h3F;
  localparam logic [1:0] QUERY_LAST  = 2'h3;
  localparam logic [1:0] QUERY_STATE = 2'h1;
  localparam logic [2:0] EXIT_FALLS  = 3'h4;
  localparam logic [7:0] FREQ_MIN    = 8'h01;

  // synchronised view of the two bus wires
  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic sda_fall;
    logic start;
    logic stop;
  } tqe_line_t;

  // serial engine phases
  typedef enum logic [3:0] {
    P_IDLE, P_HEAD, P_CMD, P_WDATA, P_RDATA,
    P_ARB_ID, P_ARB_ADDR, P_SKIP, P_WAIT_EXIT
  } tqe_phase_t;

  // addresses only a bit error makes
  function automatic logic tqe_restricted(input logic [6:0] a);
    case (a)
      7'h7F, 7'h7C, 7'h7A, 7'h76, 7'h6E, 7'h5E, 7'h3E: tqe_restricted = 1'b1;
      default: tqe_restricted = 1'b0;
    endcase
  endfunction : tqe_restricted

  // nine-bit group with odd parity
  function automatic logic tqe_odd9(input logic [8:0] g);
    tqe_odd9 = ^g;
  endfunction : tqe_odd9

  // byte-lane merge of a write
  function automatic logic [31:0] tqe_merge(input logic [31:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      tqe_merge[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : tqe_merge

endpackage : tqe_pkg

// ### design/tqe_pin_sync.sv
// module: two-stage synchroniser and edge finder for the bus wires
`timescale 1ns/10ps
`default_nettype none
module tqe_pin_sync (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // raw pins
  input  wire logic              scl_i,
  input  wire logic              sda_i,
  // synchronised view
  output tqe_pkg::tqe_line_t     line
);

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] syn;
    logic [1:0] prev;
  } tqe_sync_st_t;

  tqe_sync_st_t s_ff;
  tqe_sync_st_t nxt_s;

  // meta feeds only syn; edges compare syn with prev
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.meta = {scl_i, sda_i};
    nxt_s.syn  = s_ff.meta;
    nxt_s.prev = s_ff.syn;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '{meta: 2'h3, syn: 2'h3, prev: 2'h3};
    end else begin
      s_ff <= nxt_s;
    end
  end

  // start and stop need scl high on both samples
  assign line.scl      = s_ff.syn[1];
  assign line.sda      = s_ff.syn[0];
  assign line.scl_rise = s_ff.syn[1] & ~s_ff.prev[1];
  assign line.scl_fall = ~s_ff.syn[1] & s_ff.prev[1];
  assign line.sda_fall = ~s_ff.syn[0] & s_ff.prev[0];
  assign line.start    = s_ff.syn[1] & s_ff.prev[1] & ~s_ff.syn[0] & s_ff.prev[0];
  assign line.stop     = s_ff.syn[1] & s_ff.prev[1] & s_ff.syn[0] & ~s_ff.prev[0];

endmodule : tqe_pin_sync
`default_nettype wire

// ### design/tqe_exit_det.sv
// module: detector of the fast mode exit pattern on the bus
`timescale 1ns/10ps
`default_nettype none
module tqe_exit_det (
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rst,
  // synchronised bus
  input  wire tqe_pkg::tqe_line_t line,
  // one-cycle pulse when the pattern is complete
  output logic                   exit_seen
);

  typedef struct packed {
    logic [2:0] falls;
    logic       seen;
  } tqe_exit_st_t;

  tqe_exit_st_t s_ff;
  tqe_exit_st_t nxt_s;

  // ordinary traffic moves sda once per scl low, never four times
  always_comb begin
    nxt_s      = s_ff;
    nxt_s.seen = 1'b0;
    if (line.scl) begin
      nxt_s.falls = '0;
    end else if (line.sda_fall) begin
      if (s_ff.falls + 3'h1 == tqe_pkg::EXIT_FALLS) begin
        nxt_s.seen  = 1'b1;
        nxt_s.falls = '0;
      end else begin
        nxt_s.falls = s_ff.falls + 3'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign exit_seen = s_ff.seen;

endmodule : tqe_exit_det
`default_nettype wire

// ### design/tqe_target.sv
// module: serial bus target answering the timing query, with error recovery
// How it works
// - timing query read returns four bytes in order
// - supported byte: sync bit0, async bits 1-4
// - state bits 4-0 show enabled modes
// - state bit 7 flags overflow since last query
// - frequency byte counts half-megahertz steps
// - zero frequency only for slow oscillator
// - inaccuracy byte counts tenth-percent steps
// - all seven error categories detected and recovered
// - restricted address write or broadcast read: await exit
// - command parity error: await exit pattern only
// - write data parity error: await stop/restart
// - bad assigned-address parity: nack, await retry
// - wrong header during arbitration: nack, await stop/restart
// - illegal command format: nack, await stop/restart
// - driven bit mismatch: stop driving, await stop/restart
//
// Local design decisions: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module tqe_target #(
  parameter logic [7:0] CODE_QUERY      = 8'h99,
  parameter logic [7:0] CODE_ARB        = 8'h07,
  parameter logic [7:0] CODE_FAST       = 8'h20,
  parameter logic [7:0] CODE_DIRECT_MIN = 8'h80
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // serial bus, open drain data
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // timing counter overflow, mclk domain pulse
  input  wire logic        ovf_evt,
  // avalon-mm slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // interrupt
  output logic             irq
);

  typedef struct packed {
    tqe_pkg::tqe_phase_t               phase;
    tqe_pkg::tqe_phase_t               after;
    logic [6:0]                        cnt;
    logic [63:0]                       sh;
    logic                              ack;
    logic [1:0]                        qidx;
    logic                              ovf;
    logic                              sent_ovf;
    logic                              in_cmd;
    logic [7:0]                        cmd_code;
    logic                              arb;
    logic [6:0]                        dyn_addr;
    logic                              dyn_valid;
    logic [7:0]                        rx_byte;
    logic                              sda_oe;
    logic                              sda_o;
    logic [tqe_pkg::CTRL_W-1:0]        ctrl;
    logic [tqe_pkg::MODE_W-1:0]        sup;
    logic [tqe_pkg::MODE_W-1:0]        en;
    logic [7:0]                        freq;
    logic [7:0]                        inacc;
    logic [31:0]                       id_lo;
    logic [31:0]                       id_hi;
    logic [tqe_pkg::EV_W-1:0]          status;
    logic [tqe_pkg::EV_W-1:0]          mask;
    logic                              irq;
    logic                              wait_req;
    logic [31:0]                       rdata;
  } tqe_tgt_st_t;

  tqe_tgt_st_t        s_ff;
  tqe_tgt_st_t        nxt_s;
  tqe_pkg::tqe_line_t line;
  logic               exit_seen;
  localparam logic [1:0] QUERY_STATE_L = tqe_pkg::QUERY_STATE;

  // pins pass two flops first
  tqe_pin_sync u_sync (
    .mclk  (mclk),
    .rst   (rst),
    .scl_i (scl_i),
    .sda_i (sda_i),
    .line  (line)
  );

  // left armed alone after address or code errors
  tqe_exit_det u_exit (
    .mclk      (mclk),
    .rst       (rst),
    .line      (line),
    .exit_seen (exit_seen)
  );

  // one of the four query bytes
  function automatic logic [7:0] qbyte(input logic [1:0] i, input tqe_tgt_st_t s);
    logic [7:0] b;
    b = '0;
    case (i)
      2'h0: b[tqe_pkg::MODE_W-1:0] = s.sup;
      2'h1: begin
        b[tqe_pkg::MODE_W-1:0]       = s.sup & s.en;
        b[tqe_pkg::STATE_OVF_BIT]    = s.ovf;
      end
      2'h2: begin
        // zero only for the slow oscillator
        if (s.ctrl[tqe_pkg::CTRL_SLOW]) b = '0;
        else if (s.freq == '0) b = tqe_pkg::FREQ_MIN;
        else b = s.freq;
      end
      default: b = s.inacc;
    endcase
    return b;
  endfunction : qbyte

  // register word as software sees it
  function automatic logic [31:0] rd_word(input logic [4:0] a, input tqe_tgt_st_t s);
    logic [31:0] w;
    w = '0;
    case (a)
      tqe_pkg::OFF_CTRL:   w[tqe_pkg::CTRL_W-1:0] = s.ctrl;
      tqe_pkg::OFF_MODES: begin
        w[tqe_pkg::MODE_W-1:0] = s.sup;
        w[tqe_pkg::MODES_EN_LSB +: tqe_pkg::MODE_W] = s.en;
      end
      tqe_pkg::OFF_OSC: begin
        w[7:0] = s.freq;
        w[tqe_pkg::OSC_INACC_LSB +: 8] = s.inacc;
      end
      tqe_pkg::OFF_ID_LO:  w = s.id_lo;
      tqe_pkg::OFF_ID_HI:  w = s.id_hi;
      tqe_pkg::OFF_STATUS: w[tqe_pkg::EV_W-1:0] = s.status;
      tqe_pkg::OFF_MASK:   w[tqe_pkg::EV_W-1:0] = s.mask;
      tqe_pkg::OFF_BUSST: begin
        w[6:0] = s.dyn_addr;
        w[tqe_pkg::BUSST_VALID] = s.dyn_valid;
        w[tqe_pkg::BUSST_OVF]   = s.ovf;
        w[tqe_pkg::BUSST_ARB]   = s.arb;
        w[tqe_pkg::BUSST_RX_LSB +: 8] = s.rx_byte;
      end
      default: w = '0;
    endcase
    return w;
  endfunction : rd_word

  // engine, register slave and interrupt
  always_comb begin
    logic [tqe_pkg::EV_W-1:0] evt;
    logic [7:0]               hb;
    logic                     ovf_clr;
    logic [31:0]              wv;
    logic [tqe_pkg::EV_W-1:0] rd_clr;
    evt     = '0;
    hb      = {s_ff.sh[6:0], line.sda};
    ovf_clr = 1'b0;
    wv      = tqe_pkg::tqe_merge(rd_word(avs_address, s_ff), avs_writedata, avs_byteenable);
    rd_clr  = '0;
    nxt_s   = s_ff;

    // engine: wait-for-exit outranks start and stop
    if (!s_ff.ctrl[tqe_pkg::CTRL_EN]) begin
      nxt_s.phase  = tqe_pkg::P_IDLE;
      nxt_s.sda_oe = 1'b0;
      nxt_s.in_cmd = 1'b0;
      nxt_s.arb    = 1'b0;
    end else if (s_ff.phase == tqe_pkg::P_WAIT_EXIT) begin
      if (exit_seen) begin
        nxt_s.phase  = tqe_pkg::P_IDLE;
        nxt_s.in_cmd = 1'b0;
        nxt_s.arb    = 1'b0;
      end
    end else if (line.stop) begin
      nxt_s.phase  = tqe_pkg::P_IDLE;
      nxt_s.sda_oe = 1'b0;
      nxt_s.in_cmd = 1'b0;
      nxt_s.arb    = 1'b0;
    end else if (line.start) begin
      // a restart also ends the skip state, but not the wait for exit
      nxt_s.phase  = tqe_pkg::P_HEAD;
      nxt_s.cnt    = '0;
      nxt_s.ack    = 1'b0;
      nxt_s.sda_oe = 1'b0;
    end else if (line.scl_fall) begin
      // sda only changes while scl is low
      case (s_ff.phase)
        tqe_pkg::P_HEAD, tqe_pkg::P_ARB_ADDR:
          nxt_s.sda_oe = (s_ff.cnt == tqe_pkg::BYTE_END) && s_ff.ack;
        tqe_pkg::P_RDATA:
          nxt_s.sda_oe = (s_ff.cnt == tqe_pkg::BYTE_END) ?
                         (s_ff.qidx == tqe_pkg::QUERY_LAST) : !s_ff.sh[63];
        tqe_pkg::P_ARB_ID:
          nxt_s.sda_oe = !s_ff.sh[63];
        default:
          nxt_s.sda_oe = 1'b0;
      endcase
    end else if (line.scl_rise) begin
      nxt_s.cnt = s_ff.cnt + 7'h01;
      nxt_s.sh  = {s_ff.sh[62:0], line.sda};
      case (s_ff.phase)
        tqe_pkg::P_HEAD, tqe_pkg::P_ARB_ADDR: begin
          if (s_ff.cnt == tqe_pkg::BYTE_END) begin
            // ack bit done: enter chosen phase
            nxt_s.phase = s_ff.after;
            nxt_s.cnt   = '0;
            nxt_s.ack   = 1'b0;
            if (s_ff.after == tqe_pkg::P_RDATA) begin
              nxt_s.sh = {qbyte(2'h0, s_ff), 56'h0};
            end else if (s_ff.after == tqe_pkg::P_ARB_ID) begin
              nxt_s.sh = {s_ff.id_hi, s_ff.id_lo};
            end
          end else if (s_ff.cnt == tqe_pkg::HEAD_LAST &&
                       s_ff.phase == tqe_pkg::P_ARB_ADDR) begin
            if (tqe_pkg::tqe_odd9({1'b0, hb})) begin
              nxt_s.ack       = 1'b1;
              nxt_s.after     = tqe_pkg::P_SKIP;
              nxt_s.dyn_addr  = hb[7:1];
              nxt_s.dyn_valid = 1'b1;
              evt[tqe_pkg::EV_ADDR] = 1'b1;
            end else begin
              // no drive is the nack; a restart and broadcast read retries
              nxt_s.phase = tqe_pkg::P_SKIP;
              evt[tqe_pkg::EV_S3] = 1'b1;
            end
          end else if (s_ff.cnt == tqe_pkg::HEAD_LAST) begin
            nxt_s.phase = tqe_pkg::P_SKIP;
            if (s_ff.arb) begin
              if (hb[7:1] == tqe_pkg::ADDR_BCAST && hb[0]) begin
                if (!s_ff.dyn_valid) begin
                  nxt_s.phase = tqe_pkg::P_HEAD;
                  nxt_s.ack   = 1'b1;
                  nxt_s.after = tqe_pkg::P_ARB_ID;
                end
              end else begin
                evt[tqe_pkg::EV_S4] = 1'b1;
              end
            end else if ((tqe_pkg::tqe_restricted(hb[7:1]) && !hb[0]) ||
                         (hb[7:1] == tqe_pkg::ADDR_BCAST && hb[0])) begin
              nxt_s.phase = tqe_pkg::P_WAIT_EXIT;
              evt[tqe_pkg::EV_S0] = 1'b1;
            end else if (hb[7:1] == tqe_pkg::ADDR_BCAST) begin
              nxt_s.phase = tqe_pkg::P_HEAD;
              nxt_s.ack   = 1'b1;
              nxt_s.after = tqe_pkg::P_CMD;
            end else if (s_ff.dyn_valid && hb[7:1] == s_ff.dyn_addr) begin
              if (s_ff.in_cmd && s_ff.cmd_code == CODE_QUERY) begin
                if (hb[0]) begin
                  nxt_s.phase = tqe_pkg::P_HEAD;
                  nxt_s.ack   = 1'b1;
                  nxt_s.after = tqe_pkg::P_RDATA;
                  nxt_s.qidx  = '0;
                end else begin
                  evt[tqe_pkg::EV_S5] = 1'b1;
                end
              end else if (!s_ff.in_cmd && !hb[0]) begin
                nxt_s.phase = tqe_pkg::P_HEAD;
                nxt_s.ack   = 1'b1;
                nxt_s.after = tqe_pkg::P_WDATA;
              end
            end
          end
        end
        tqe_pkg::P_CMD: begin
          if (s_ff.cnt == tqe_pkg::BYTE_END) begin
            nxt_s.cnt   = '0;
            nxt_s.phase = tqe_pkg::P_SKIP;
            if (!tqe_pkg::tqe_odd9({s_ff.sh[7:0], line.sda})) begin
              // a corrupted code could have been a fast mode entry
              nxt_s.phase = tqe_pkg::P_WAIT_EXIT;
              evt[tqe_pkg::EV_S1] = 1'b1;
            end else if (s_ff.sh[7:0] == CODE_ARB) begin
              nxt_s.arb = 1'b1;
            end else if (s_ff.sh[7:3] == CODE_FAST[7:3]) begin
              nxt_s.phase = tqe_pkg::P_WAIT_EXIT;
            end else if (s_ff.sh[7:0] >= CODE_DIRECT_MIN) begin
              nxt_s.in_cmd   = 1'b1;
              nxt_s.cmd_code = s_ff.sh[7:0];
            end
          end
        end
        tqe_pkg::P_WDATA: begin
          if (s_ff.cnt == tqe_pkg::BYTE_END) begin
            nxt_s.cnt = '0;
            if (!tqe_pkg::tqe_odd9({s_ff.sh[7:0], line.sda})) begin
              nxt_s.phase = tqe_pkg::P_SKIP;
              evt[tqe_pkg::EV_S2] = 1'b1;
            end else begin
              nxt_s.rx_byte = s_ff.sh[7:0];
              evt[tqe_pkg::EV_WRX] = 1'b1;
            end
          end
        end
        tqe_pkg::P_RDATA: begin
          // the controller may pull the transition bit: not watched
          if (s_ff.ctrl[tqe_pkg::CTRL_MON] && s_ff.cnt != tqe_pkg::BYTE_END &&
              line.sda != !s_ff.sda_oe) begin
            nxt_s.phase  = tqe_pkg::P_SKIP;
            nxt_s.sda_oe = 1'b0;
            evt[tqe_pkg::EV_S6] = 1'b1;
          end else if (s_ff.cnt == tqe_pkg::BYTE_END) begin
            nxt_s.cnt = '0;
            if (s_ff.qidx == QUERY_STATE_L) begin
              ovf_clr = s_ff.sent_ovf;
            end
            if (s_ff.qidx == tqe_pkg::QUERY_LAST) begin
              nxt_s.phase = tqe_pkg::P_SKIP;
              evt[tqe_pkg::EV_QUERY] = 1'b1;
            end else begin
              nxt_s.qidx = s_ff.qidx + 2'h1;
              nxt_s.sh   = {qbyte(s_ff.qidx + 2'h1, s_ff), 56'h0};
              if (s_ff.qidx + 2'h1 == QUERY_STATE_L) begin
                nxt_s.sent_ovf = s_ff.ovf;
              end
            end
          end
        end
        tqe_pkg::P_ARB_ID: begin
          // arbitration bits are exempt from monitoring; a loss just waits
          if (!s_ff.sda_oe && !line.sda) begin
            nxt_s.phase = tqe_pkg::P_SKIP;
          end else if (s_ff.cnt == tqe_pkg::ARB_ID_LAST) begin
            nxt_s.phase = tqe_pkg::P_ARB_ADDR;
            nxt_s.cnt   = '0;
          end
        end
        default: nxt_s.cnt = '0;
      endcase
    end

    // a new overflow wins over the clear
    nxt_s.ovf = (s_ff.ovf & ~ovf_clr) | ovf_evt;

    // avalon slave: one wait cycle, answer on the following edge
    nxt_s.wait_req = 1'b1;
    if ((avs_read || avs_write) && s_ff.wait_req) begin
      nxt_s.wait_req = 1'b0;
      if (avs_read) nxt_s.rdata = rd_word(avs_address, s_ff);
    end
    if (avs_write && !s_ff.wait_req) begin
      case (avs_address)
        tqe_pkg::OFF_CTRL:  nxt_s.ctrl  = wv[tqe_pkg::CTRL_W-1:0];
        tqe_pkg::OFF_MODES: begin
          nxt_s.sup = wv[tqe_pkg::MODE_W-1:0];
          nxt_s.en  = wv[tqe_pkg::MODES_EN_LSB +: tqe_pkg::MODE_W];
        end
        tqe_pkg::OFF_OSC: begin
          nxt_s.freq  = wv[7:0];
          nxt_s.inacc = wv[tqe_pkg::OSC_INACC_LSB +: 8];
        end
        tqe_pkg::OFF_ID_LO: nxt_s.id_lo = wv;
        tqe_pkg::OFF_ID_HI: nxt_s.id_hi = wv;
        tqe_pkg::OFF_MASK:  nxt_s.mask  = wv[tqe_pkg::EV_W-1:0];
        default: nxt_s.id_lo = s_ff.id_lo;
      endcase
    end
    // clear only bits handed out; later events survive
    if (avs_read && !s_ff.wait_req && avs_address == tqe_pkg::OFF_STATUS) begin
      rd_clr = s_ff.rdata[tqe_pkg::EV_W-1:0];
    end
    nxt_s.status = (s_ff.status & ~rd_clr) | evt;
    nxt_s.irq    = |(nxt_s.status & nxt_s.mask);
  end

  // all state in one register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_ff          <= '0;
      s_ff.phase    <= tqe_pkg::P_IDLE;
      s_ff.after    <= tqe_pkg::P_IDLE;
      s_ff.ctrl     <= tqe_pkg::CTRL_RST;
      s_ff.sup      <= tqe_pkg::SUP_RST;
      s_ff.en       <= tqe_pkg::EN_RST;
      s_ff.freq     <= tqe_pkg::FREQ_RST;
      s_ff.inacc    <= tqe_pkg::INACC_RST;
      s_ff.id_lo    <= tqe_pkg::ID_LO_RST;
      s_ff.id_hi    <= tqe_pkg::ID_HI_RST;
      s_ff.wait_req <= 1'b1;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs from the state register
  assign sda_o           = s_ff.sda_o;
  assign sda_oe          = s_ff.sda_oe;
  assign avs_readdata    = s_ff.rdata;
  assign avs_waitrequest = s_ff.wait_req;
  assign irq             = s_ff.irq;

endmodule : tqe_target
`default_nettype wire

// ### tb/tqe_target_checker.sv
// checker: port properties of the timing query target
`timescale 1ns/10ps
`default_nettype none
module tqe_target_checker (
  // clock and bus pins
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_oe,
  // register bus
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic        avs_waitrequest,
  input wire logic [31:0] avs_readdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // answer one cycle after the request, one cycle long
  a_req_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("answer late");
  a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  a_idle_quiet: assert property (!avs_read && !avs_write && avs_waitrequest
    |=> avs_waitrequest) else $error("answer without request");
  // read data hold to the next read
  a_rdata_hold: assert property (avs_waitrequest && $past(avs_waitrequest)
    |-> $stable(avs_readdata)) else $error("read data moved");
  a_write_keep: assert property ($fell(avs_waitrequest) && avs_write
    |-> $stable(avs_readdata)) else $error("write changed read data");
  // drive starts only with scl low
  a_oe_after_fall: assert property ($rose(sda_oe) |-> !$past(scl_i, 2))
    else $error("drive began with clock high");
  // stop and start release the data line
  a_stop_release: assert property (scl_i && $rose(sda_i) |-> ##[1:6] !sda_oe)
    else $error("held after stop");
  a_start_release: assert property (scl_i && $fell(sda_i) |-> ##[1:6] !sda_oe)
    else $error("held after start");
endmodule : tqe_target_checker
`default_nettype wire

// ### tb/tqe_ctl.sv
// partner: bus controller model with open-drain data and pull-up
`timescale 1ns/10ps
`default_nettype none
module tqe_ctl (
  // clock and target drive
  input wire logic mclk,
  input wire logic sda_oe,
  // bus wires
  output logic     scl,
  output logic     sda
);
  logic c_sda;
  // pull-up: a released line reads high
  assign sda = c_sda & ~sda_oe;
  initial begin
    scl = 1'b1;
    c_sda = 1'b1;
  end
  task automatic drv(input logic c, input logic d, input int n);
    scl <= c;
    c_sda <= d;
    repeat (n) @(posedge mclk);
  endtask : drv
  // scl idles high between frames
  task automatic start;
    if (!scl) drv(1'b0, 1'b1, 2);
    drv(1'b1, 1'b1, 4);
    drv(1'b1, 1'b0, 4);
    drv(1'b0, 1'b0, 2);
  endtask : start
  task automatic stop;
    drv(1'b0, 1'b0, 2);
    drv(1'b1, 1'b0, 4);
    drv(1'b1, 1'b1, 4);
  endtask : stop
  // msb first; ones leave the line to the target
  task automatic xfer(input logic [63:0] v, input int n, output logic [63:0] r);
    r = '0;
    for (int i = n - 1; i >= 0; i--) begin
      drv(1'b0, v[i], 2);
      drv(1'b1, v[i], 4);
      r[i] = sda;
      drv(1'b0, v[i], 2);
    end
  endtask : xfer
  // four sda falls in one scl low, then stop
  task automatic fast_exit;
    repeat (4) begin
      drv(1'b0, 1'b1, 3);
      drv(1'b0, 1'b0, 3);
    end
    stop;
  endtask : fast_exit
endmodule : tqe_ctl
`default_nettype wire

// ### tb/tqe_target_test.sv
// testbench: registers, arbitration, timing query and error recovery
`timescale 1ns/10ps
`default_nettype none
module tqe_target_test;
  localparam logic [7:0] CQ = 8'h99;
  localparam logic [7:0] CA = 8'h07;
  localparam logic [6:0] DA = 7'h21;
  logic        mclk = 1'b0, rst = 1'b1, ovf_evt = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        scl, sda, sda_oe, irq, wreq;
  logic [4:0]  adr = 5'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [63:0] r;
  int          miscompares = 0, total_checks = 0;
  tqe_ctl tqe_ctl_i (.mclk(mclk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  tqe_target #(.CODE_QUERY(CQ), .CODE_ARB(CA)) tqe_target_i (.mclk(mclk), .rst(rst),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .ovf_evt(ovf_evt),
    .avs_address(adr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdat),
    .avs_byteenable(4'hF), .avs_readdata(rdat), .avs_waitrequest(wreq), .irq(irq));
  initial forever #12.5 mclk = ~mclk;
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // held until waitrequest low, then an idle edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge mclk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk);
  endtask : acc
  task automatic head(input logic [7:0] c, input logic [8:0] h);
    tqe_ctl_i.start;
    tqe_ctl_i.xfer(9'h1F9, 9, r);
    tqe_ctl_i.xfer({c, ~^c}, 9, r);
    tqe_ctl_i.start;
    tqe_ctl_i.xfer(h, 9, r);
  endtask : head
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    report_and_stop;
  end
  initial begin
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (3) @(posedge mclk);
    acc(1'b0, tqe_pkg::OFF_OSC, 32'h0);
    chk(q, 32'h0A50);
    acc(1'b0, 5'h02, 32'h0);
    chk(q, 32'h0); // unaligned reads zero
    // arbitration: bad parity, then retry
    head(CA, 9'h1FB);
    for (int p = 0; p < 2; p++) begin
      if (p == 1) tqe_ctl_i.start;
      if (p == 1) tqe_ctl_i.xfer(9'h1FB, 9, r);
      tqe_ctl_i.xfer('1, 64, r);
      chk(r, {tqe_pkg::ID_HI_RST, tqe_pkg::ID_LO_RST});
      tqe_ctl_i.xfer({DA, ~^DA ^ (p == 0), 1'b1}, 9, r);
      chk(r[0], p == 0);
    end
    tqe_ctl_i.stop;
    acc(1'b0, tqe_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h208);
    acc(1'b1, tqe_pkg::OFF_MODES, 32'h0113);
    acc(1'b1, tqe_pkg::OFF_OSC, 32'h0A14);
    acc(1'b1, tqe_pkg::OFF_MASK, 32'h80);
    ovf_evt <= 1'b1;
    @(posedge mclk);
    ovf_evt <= 1'b0;
    // two queries: overflow once, then slow oscillator
    for (int k = 0; k < 2; k++) begin
      head(CQ, {DA, 2'b11});
      tqe_ctl_i.xfer('1, 36, r);
      tqe_ctl_i.stop;
      chk(r[35:18], {8'h13, 1'b1, k ? 8'h01 : 8'h81, 1'b1});
      chk(r[17:0], {k ? 8'h00 : 8'h14, 1'b1, 8'h0A, 1'b0});
      chk(irq, 1'b1);
      acc(1'b0, tqe_pkg::OFF_STATUS, 32'h0);
      chk(q, 32'h80);
      acc(1'b1, tqe_pkg::OFF_CTRL, 32'h7);
      chk(irq, 1'b0);
    end
    // restricted write, broadcast read, bad code parity
    for (int e = 0; e < 3; e++) begin
      if (e < 2) tqe_ctl_i.start;
      if (e < 2) tqe_ctl_i.xfer(e ? 9'h1FB : 9'h0F9, 9, r);
      if (e == 2) head(~CQ ^ 8'h7F, 9'h1F9);
      if (e == 2) tqe_ctl_i.xfer({CQ, ^CQ}, 9, r);
      tqe_ctl_i.start;
      tqe_ctl_i.xfer({DA, 2'b11}, 9, r);
      chk(r[0], 1'b1);
      tqe_ctl_i.fast_exit;
      acc(1'b0, tqe_pkg::OFF_STATUS, 32'h0);
      chk(q, e == 2 ? 32'h2 : 32'h1);
    end
    // good write byte, then bad parity
    tqe_ctl_i.start;
    tqe_ctl_i.xfer({DA, 2'b01}, 9, r);
    tqe_ctl_i.xfer({8'h3C, ~^8'h3C, 8'hA5, ^8'hA5}, 18, r);
    tqe_ctl_i.stop;
    acc(1'b0, tqe_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h104);
    acc(1'b0, tqe_pkg::OFF_BUSST, 32'h0);
    chk(q[23:16], 8'h3C);
    // write header while the query is pending
    head(CQ, {DA, 2'b01});
    tqe_ctl_i.stop;
    chk(r[0], 1'b1);
    acc(1'b0, tqe_pkg::OFF_STATUS, 32'h0);
    chk(q, 32'h20);
    report_and_stop;
  end
endmodule : tqe_target_test
bind tqe_target tqe_target_checker tqe_target_checker_i (.mclk(mclk), .rst(rst),
  .scl_i(scl_i), .sda_i(sda_i), .sda_oe(sda_oe), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata));
`default_nettype wire
